// File: pkg/cac_pkg.sv
package cac_pkg;

   // ---------------------------------------------------------------
   // Converter geometry and configuration word layout
   // ---------------------------------------------------------------
   localparam int CHANNELS = 64;
   localparam int WORD20 = 20;
   localparam int WORD16 = 16;
   localparam int CFG_W = 16;
   localparam int CFG_CLKDIV = 13;
   localparam int CFG_RANGE_HI = 10;
   localparam int CFG_RANGE_LO = 9;
   localparam int CFG_FORMAT = 8;
   localparam int CFG_VERSION = 7;
   localparam int CLK_DIV_ON = 4;
   localparam logic [1:0] RANGE_3 = 2'h3;
   localparam logic [1:0] RANGE_2 = 2'h2;
   localparam logic [1:0] RANGE_1 = 2'h1;
   // Full scale in units of 0.01 pC
   localparam logic [WORD20-1:0] FS_150PC = 20'h0_3a98;
   localparam logic [WORD20-1:0] FS_100PC = 20'h0_2710;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam longint SYS_CLK_HZ = 40_000_000;
   localparam int SYS_CLK_NS = 25;
   localparam longint INT_CLK_MAX_HZ = 5_000_000;
   localparam int INTEGRATION_TOGGLE_TIME_US = 276;
   localparam int INTEGRATION_TOGGLE_ICLK = int'(INTEGRATION_TOGGLE_TIME_US * INT_CLK_MAX_HZ / 1_000_000);
   localparam int READY_PULSE_NS = 100;
   localparam int READY_PULSE_CYC = (READY_PULSE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
   localparam int SHIFT_PERIOD_NS = 400;
   localparam int SHIFT_HALF_CYC = SHIFT_PERIOD_NS / 2 / SYS_CLK_NS;
   localparam int MCLK_DIV = 2;

   // ---------------------------------------------------------------
   // Host register map (byte addresses) and fields
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_HALF = 8'h04;
   localparam logic [7:0] ADDR_DELAY = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_DATA = 8'h10;
   localparam logic [7:0] ADDR_INT_STAT = 8'h14;
   localparam logic [7:0] ADDR_INT_EN = 8'h18;
   localparam logic [7:0] ADDR_INT_CLR = 8'h1c;
   localparam int CTRL_W = 12;
   localparam int CTRL_RUN = 0;
   localparam int CTRL_TIMED = 1;
   localparam int CTRL_EARLY = 2;
   localparam int CTRL_FORMAT = 3;
   localparam int CTRL_CLKDIV = 4;
   localparam int CTRL_VERSION = 5;
   localparam int CTRL_RANGE_LO = 6;
   localparam int CTRL_NDEV_LO = 8;
   localparam logic [CTRL_W-1:0] CTRL_RST = 12'h1c0;
   localparam logic [31:0] HALF_RST = 32'h0000_2710;
   localparam int IRQ_N = 4;
   localparam int IRQ_WORD = 0;
   localparam int IRQ_FRAME = 1;
   localparam int IRQ_OVERRUN = 2;
   localparam int IRQ_LATE = 3;

endpackage : cac_pkg

// File: pkg/cac_link_if.sv
`timescale 1ns/10ps
interface cac_link_if
   import cac_pkg::*;
();
   logic integration_toggle;
   logic result_ready_n;
   logic shift_clock;
   logic data_out;
   logic [CFG_W-1:0] cfg_word;

   modport dev(input integration_toggle, input shift_clock, input cfg_word,
               output result_ready_n, output data_out);
   modport host(output integration_toggle, output shift_clock, output cfg_word,
                input result_ready_n, input data_out);
endinterface : cac_link_if

// File: hdl/cac_pin_sync.sv
`timescale 1ns/10ps
module cac_pin_sync (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Pin and filtered view
   input wire logic pin,
   output logic level,
   output logic rise,
   output logic fall
);
   logic [2:0] sh_q;
   logic [2:0] sh_d;
   logic lvl_q, lvl_d, rise_q, rise_d, fall_q, fall_d;

   // A change counts only once stages two and three agree
   always_comb begin
      sh_d = {sh_q[1:0], pin};
      lvl_d = (sh_q[1] == sh_q[2]) ? sh_q[2] : lvl_q;
      rise_d = lvl_d & ~lvl_q;
      fall_d = ~lvl_d & lvl_q;
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sh_q <= 3'h0;
         lvl_q <= 1'b0;
         rise_q <= 1'b0;
         fall_q <= 1'b0;
      end else begin
         sh_q <= sh_d;
         lvl_q <= lvl_d;
         rise_q <= rise_d;
         fall_q <= fall_d;
      end
   end

   assign level = lvl_q;
   assign rise = rise_q;
   assign fall = fall_q;
endmodule : cac_pin_sync

// File: hdl/cac_device.sv
`timescale 1ns/10ps
module cac_device
   import cac_pkg::*;
#(
   parameter int INTEGRATION_TOGGLE_CYC = INTEGRATION_TOGGLE_ICLK,
   parameter int PULSE_CYC = READY_PULSE_CYC,
   parameter int MDIV = MCLK_DIV,
   parameter logic [WORD20-1:0] FS_R1 = 20'h0_1388,
   parameter logic [WORD20-1:0] FS_R0 = 20'h0_09c4
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Link to host
   cac_link_if.dev link,
   // Converter side
   input wire logic [CHANNELS*WORD20-1:0] chan_charge,
   input wire logic chain_in,
   output logic over_range,
   output logic clock_fault,
   output logic integration_toggle_busy
);
   localparam int SR_W = CHANNELS * WORD20;
   localparam longint MCLK_HZ = SYS_CLK_HZ / MDIV;

   logic tog_rise, tog_fall, sclk_rise, chain_lvl;
   logic clkdiv, fmt;
   logic [7:0] mcnt_q, mcnt_d;
   logic [1:0] idiv_q, idiv_d;
   logic [15:0] cnt_q, cnt_d;
   logic [7:0] pcnt_q, pcnt_d;
   logic busy_q, busy_d, rdy_n_q, rdy_n_d, ovr_q, ovr_d, flt_q, flt_d;
   logic [SR_W-1:0] sr_q, sr_d, load_vec;
   logic [WORD20-1:0] fs;
   logic any_ovr, mtick, iclk_en;

   cac_pin_sync u_tog (.sys_clk(sys_clk), .nrst(nrst), .pin(link.integration_toggle),
                       .level(), .rise(tog_rise), .fall(tog_fall));
   cac_pin_sync u_sclk (.sys_clk(sys_clk), .nrst(nrst), .pin(link.shift_clock),
                        .level(), .rise(sclk_rise), .fall());
   cac_pin_sync u_chain (.sys_clk(sys_clk), .nrst(nrst), .pin(chain_in),
                         .level(chain_lvl), .rise(), .fall());

   assign clkdiv = link.cfg_word[CFG_CLKDIV];
   assign fmt = link.cfg_word[CFG_FORMAT];

   // ---------------------------------------------------------------
   // Range clamp and output packing
   // ---------------------------------------------------------------
   always_comb begin
      logic [WORD20-1:0] ch;
      ch = '0;
      unique case (link.cfg_word[CFG_RANGE_HI:CFG_RANGE_LO])
         RANGE_3: fs = FS_150PC;
         RANGE_2: fs = FS_100PC;
         RANGE_1: fs = FS_R1;
         default: fs = FS_R0;
      endcase
      any_ovr = 1'b0;
      load_vec = '0;
      for (int c = 0; c < CHANNELS; c++) begin
         ch = chan_charge[c*WORD20 +: WORD20];
         if (ch > fs) begin
            ch = fs;
            any_ovr = 1'b1;
         end
         if (fmt) begin
            load_vec[SR_W-1-c*WORD20 -: WORD20] = ch;
         end else begin
            load_vec[SR_W-1-c*WORD16 -: WORD16] = ch[WORD20-1 -: WORD16];
         end
      end
   end

   // ---------------------------------------------------------------
   // Internal clock, conversion and result strobe
   // ---------------------------------------------------------------
   always_comb begin
      mtick = (mcnt_q == 8'(MDIV - 1));
      mcnt_d = mtick ? 8'h00 : mcnt_q + 8'h01;
      idiv_d = idiv_q;
      if (mtick) begin
         idiv_d = idiv_q + 2'h1;
      end
      // Divider by four keeps the internal rate at the master rate over four
      iclk_en = mtick & (~clkdiv | (idiv_q == 2'(CLK_DIV_ON - 1)));
      flt_d = clkdiv ? (MCLK_HZ > INT_CLK_MAX_HZ * CLK_DIV_ON)
                     : (MCLK_HZ > INT_CLK_MAX_HZ);
      busy_d = busy_q;
      cnt_d = cnt_q;
      pcnt_d = pcnt_q;
      rdy_n_d = rdy_n_q;
      ovr_d = ovr_q;
      sr_d = sr_q;
      if (!rdy_n_q) begin
         if (pcnt_q == 8'h00) begin
            rdy_n_d = 1'b1;
         end else begin
            pcnt_d = pcnt_q - 8'h01;
         end
      end
      if (sclk_rise) begin
         // Chain input enters at the tail so upstream data follows ours
         sr_d = {sr_q[SR_W-2:0], chain_lvl};
         if (!fmt) begin
            // Short words leave the low bits unused, so chain data must follow word 63
            sr_d[SR_W-CHANNELS*WORD16] = chain_lvl;
         end
      end
      if (tog_rise | tog_fall) begin
         // Either edge closes one integration and starts its conversion
         busy_d = 1'b1;
         cnt_d = 16'(INTEGRATION_TOGGLE_CYC - 1);
      end else if (busy_q && iclk_en) begin
         // Counted in internal clocks, so a slower clock converts longer
         if (cnt_q == 16'h0000) begin
            busy_d = 1'b0;
            sr_d = load_vec;
            ovr_d = any_ovr;
            rdy_n_d = 1'b0;
            pcnt_d = 8'(PULSE_CYC - 1);
         end else begin
            cnt_d = cnt_q - 16'h0001;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         mcnt_q <= 8'h00;
         idiv_q <= 2'h0;
         busy_q <= 1'b0;
         cnt_q <= 16'h0000;
         pcnt_q <= 8'h00;
         rdy_n_q <= 1'b1;
         ovr_q <= 1'b0;
         flt_q <= 1'b0;
         sr_q <= '0;
      end else begin
         mcnt_q <= mcnt_d;
         idiv_q <= idiv_d;
         busy_q <= busy_d;
         cnt_q <= cnt_d;
         pcnt_q <= pcnt_d;
         rdy_n_q <= rdy_n_d;
         ovr_q <= ovr_d;
         flt_q <= flt_d;
         sr_q <= sr_d;
      end
   end

   assign link.result_ready_n = rdy_n_q;
   assign link.data_out = sr_q[SR_W-1];
   assign over_range = ovr_q;
   assign clock_fault = flt_q;
   assign integration_toggle_busy = busy_q;
endmodule : cac_device

// File: hdl/cac_host.sv
`timescale 1ns/10ps
module cac_host
   import cac_pkg::*;
#(
   parameter int HALF_CYC = SHIFT_HALF_CYC
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Interrupt
   output logic irq,
   // Link to converters
   cac_link_if.host link
);
   typedef enum logic [1:0] {HS_IDLE, HS_WAIT, HS_LOW, HS_HIGH} cac_hstate_t;

   cac_hstate_t st_q, st_d;
   logic rdy_fall, dat_lvl;
   logic [CTRL_W-1:0] ctrl_q, ctrl_d;
   logic [31:0] half_q, half_d, delay_q, delay_d, hcnt_q, hcnt_d, dly_q, dly_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d;
   logic tog_q, tog_d, sclk_q, sclk_d, valid_q, valid_d;
   logic [IRQ_N-1:0] stat_q, stat_d, en_q, en_d, ev;
   logic [CFG_W-1:0] cfg_q, cfg_d;
   logic [7:0] ph_q, ph_d;
   logic [15:0] bits_q, bits_d, total_bits;
   logic [4:0] wbits_q, wbits_d, word_w;
   logic [WORD20-1:0] word_q, word_d, data_q, data_d, word_nx;
   logic tog_edge, start_now, shifting, acc, setup, mapped, timed, early;

   cac_pin_sync u_rdy (.sys_clk(sys_clk), .nrst(nrst), .pin(link.result_ready_n),
                       .level(), .rise(), .fall(rdy_fall));
   cac_pin_sync u_dat (.sys_clk(sys_clk), .nrst(nrst), .pin(link.data_out),
                       .level(dat_lvl), .rise(), .fall());

   assign timed = ctrl_q[CTRL_TIMED];
   assign early = ctrl_q[CTRL_EARLY];
   assign word_w = ctrl_q[CTRL_FORMAT] ? 5'(WORD20) : 5'(WORD16);
   assign total_bits = 16'(word_w) * 16'(CHANNELS) * {12'h000, ctrl_q[CTRL_NDEV_LO +: 4]};
   assign shifting = (st_q == HS_LOW) || (st_q == HS_HIGH);
   assign word_nx = {word_q[WORD20-2:0], dat_lvl};

   // ---------------------------------------------------------------
   // Register bus, toggle generator, readout engine
   // ---------------------------------------------------------------
   always_comb begin
      ctrl_d = ctrl_q;
      half_d = half_q;
      delay_d = delay_q;
      en_d = en_q;
      valid_d = valid_q;
      data_d = data_q;
      tog_d = tog_q;
      hcnt_d = hcnt_q;
      st_d = st_q;
      sclk_d = sclk_q;
      ph_d = ph_q;
      bits_d = bits_q;
      wbits_d = wbits_q;
      word_d = word_q;
      dly_d = dly_q;
      ev = '0;
      tog_edge = 1'b0;
      setup = psel & penable & ~pready_q;
      acc = psel & penable & pready_q;
      mapped = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);
      pready_d = setup;
      pslverr_d = setup & ~mapped;
      prdata_d = prdata_q;
      if (setup) begin
         unique case (paddr)
            ADDR_CTRL: prdata_d = {20'h0_0000, ctrl_q};
            ADDR_HALF: prdata_d = half_q;
            ADDR_DELAY: prdata_d = delay_q;
            ADDR_STATUS: prdata_d = {28'h000_0000, tog_q, valid_q, st_q != HS_IDLE, shifting};
            ADDR_DATA: prdata_d = {12'h000, data_q};
            ADDR_INT_STAT: prdata_d = {28'h000_0000, stat_q};
            ADDR_INT_EN: prdata_d = {28'h000_0000, en_q};
            default: prdata_d = 32'h0000_0000;
         endcase
      end
      // Toggle runs on the shared system clock so edges stay synchronous
      if (ctrl_q[CTRL_RUN]) begin
         if (hcnt_q == 32'h0000_0000) begin
            tog_d = ~tog_q;
            hcnt_d = half_q;
            tog_edge = 1'b1;
         end else begin
            hcnt_d = hcnt_q - 32'h0000_0001;
         end
      end else begin
         hcnt_d = half_q;
      end
      // Early mode starts on the edge and accepts the overwrite hazard
      start_now = (early & tog_edge) | (~timed & ~early & rdy_fall);
      unique case (st_q)
         HS_IDLE: begin
            if (timed && !early && tog_edge) begin
               st_d = HS_WAIT;
               dly_d = delay_q;
            end
         end
         HS_WAIT: begin
            if (dly_q != 32'h0000_0000) begin
               dly_d = dly_q - 32'h0000_0001;
            end
         end
         HS_LOW: begin
            if (ph_q == 8'h00) begin
               sclk_d = 1'b1;
               ph_d = 8'(HALF_CYC - 1);
               bits_d = bits_q - 16'h0001;
               word_d = word_nx;
               wbits_d = wbits_q + 5'h01;
               if (wbits_q + 5'h01 == word_w) begin
                  data_d = word_nx;
                  word_d = '0;
                  wbits_d = 5'h00;
                  valid_d = 1'b1;
                  ev[IRQ_WORD] = 1'b1;
                  ev[IRQ_OVERRUN] = valid_q;
               end
               st_d = HS_HIGH;
            end else begin
               ph_d = ph_q - 8'h01;
            end
         end
         HS_HIGH: begin
            if (ph_q == 8'h00) begin
               sclk_d = 1'b0;
               ph_d = 8'(HALF_CYC - 1);
               if (bits_q == 16'h0000) begin
                  st_d = HS_IDLE;
                  ev[IRQ_FRAME] = 1'b1;
               end else begin
                  st_d = HS_LOW;
               end
            end else begin
               ph_d = ph_q - 8'h01;
            end
         end
      endcase
      if (start_now || (st_q == HS_WAIT && dly_q == 32'h0000_0000)) begin
         if (!shifting) begin
            st_d = HS_LOW;
            ph_d = 8'(HALF_CYC - 1);
            bits_d = total_bits;
            wbits_d = 5'h00;
            word_d = '0;
         end
      end
      // New results landing mid-frame have replaced the ones being read
      if (rdy_fall && shifting) begin
         ev[IRQ_OVERRUN] = 1'b1;
      end
      if (tog_edge && shifting && !early) begin
         ev[IRQ_LATE] = 1'b1;
      end
      if (acc && pwrite) begin
         unique case (paddr)
            ADDR_CTRL: ctrl_d = pwdata[CTRL_W-1:0];
            ADDR_HALF: half_d = pwdata;
            ADDR_DELAY: delay_d = pwdata;
            ADDR_INT_EN: en_d = pwdata[IRQ_N-1:0];
            default: ;
         endcase
      end
      if (acc && !pwrite && paddr == ADDR_DATA && !(ev[IRQ_WORD])) begin
         valid_d = 1'b0;
      end
      stat_d = stat_q | ev;
      if (acc && pwrite && paddr == ADDR_INT_CLR) begin
         stat_d = (stat_q & ~pwdata[IRQ_N-1:0]) | ev;
      end
      irq_d = |(stat_q & en_q);
      cfg_d = '0;
      cfg_d[CFG_CLKDIV] = ctrl_q[CTRL_CLKDIV];
      cfg_d[CFG_RANGE_HI:CFG_RANGE_LO] = ctrl_q[CTRL_RANGE_LO +: 2];
      cfg_d[CFG_FORMAT] = ctrl_q[CTRL_FORMAT];
      cfg_d[CFG_VERSION] = ctrl_q[CTRL_VERSION];
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_q <= CTRL_RST;
         half_q <= HALF_RST;
         delay_q <= 32'h0000_0000;
         en_q <= '0;
         stat_q <= '0;
         valid_q <= 1'b0;
         data_q <= '0;
         tog_q <= 1'b0;
         hcnt_q <= 32'h0000_0000;
         st_q <= HS_IDLE;
         sclk_q <= 1'b0;
         ph_q <= 8'h00;
         bits_q <= 16'h0000;
         wbits_q <= 5'h00;
         word_q <= '0;
         dly_q <= 32'h0000_0000;
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         irq_q <= 1'b0;
         cfg_q <= '0;
      end else begin
         ctrl_q <= ctrl_d;
         half_q <= half_d;
         delay_q <= delay_d;
         en_q <= en_d;
         stat_q <= stat_d;
         valid_q <= valid_d;
         data_q <= data_d;
         tog_q <= tog_d;
         hcnt_q <= hcnt_d;
         st_q <= st_d;
         sclk_q <= sclk_d;
         ph_q <= ph_d;
         bits_q <= bits_d;
         wbits_q <= wbits_d;
         word_q <= word_d;
         dly_q <= dly_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         irq_q <= irq_d;
         cfg_q <= cfg_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign irq = irq_q;
   assign link.integration_toggle = tog_q;
   assign link.shift_clock = sclk_q;
   assign link.cfg_word = cfg_q;
endmodule : cac_host

// File: tb/cac_link_checker.sv
`timescale 1ns/10ps
module cac_link_checker
   import cac_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Link signals
   input wire logic integration_toggle,
   input wire logic result_ready_n,
   input wire logic shift_clock,
   input wire logic data_out,
   input wire logic [CFG_W-1:0] cfg_word
);
   // ---------------------------------------------------------------
   // Conversion tracking
   // ---------------------------------------------------------------
   logic tog_q;
   logic tog_d;
   logic integration_toggle_q;
   logic integration_toggle_d;
   logic edge_c;
   logic [8:0] cnt_q;
   logic [8:0] cnt_d;

   always_comb begin
      edge_c = integration_toggle != tog_q;
      tog_d = integration_toggle;
      // Saturate so a long idle spell never wraps into the legal window
      cnt_d = edge_c ? 9'h000 : ((cnt_q == 9'h1ff) ? cnt_q : cnt_q + 9'h001);
      integration_toggle_d = edge_c ? 1'b1 : (!result_ready_n ? 1'b0 : integration_toggle_q);
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         tog_q <= 1'b0;
         integration_toggle_q <= 1'b0;
         cnt_q <= 9'h000;
      end else begin
         tog_q <= tog_d;
         integration_toggle_q <= integration_toggle_d;
         cnt_q <= cnt_d;
      end
   end

   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);

   property p_ready_pulse;
      $fell(result_ready_n) |-> !result_ready_n [*4] ##1 result_ready_n;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("ready strobe width wrong");

   property p_integration_toggle_nodiv;
      $fell(result_ready_n) && !cfg_word[CFG_CLKDIV] |-> cnt_q inside {[56:96]};
   endproperty
   a_integration_toggle_nodiv: assert property (p_integration_toggle_nodiv)
      else $error("conversion time wrong without divider");

   property p_integration_toggle_div;
      $fell(result_ready_n) && cfg_word[CFG_CLKDIV] |-> cnt_q inside {[224:264]};
   endproperty
   a_integration_toggle_div: assert property (p_integration_toggle_div)
      else $error("conversion time wrong with divider");

   property p_sc_high;
      $rose(shift_clock) |-> shift_clock [*8] ##1 !shift_clock;
   endproperty
   a_sc_high: assert property (p_sc_high)
      else $error("shift clock high phase wrong");

   property p_sc_low;
      $fell(shift_clock) |-> !shift_clock [*8];
   endproperty
   a_sc_low: assert property (p_sc_low)
      else $error("shift clock low phase too short");

   property p_data_setup;
      $rose(shift_clock) && $stable(result_ready_n) |-> $stable(data_out);
   endproperty
   a_data_setup: assert property (p_data_setup)
      else $error("serial data moved at shift clock rise");

   property p_cfg_reserved;
      (cfg_word & 16'hd87f) == 16'h0000;
   endproperty
   a_cfg_reserved: assert property (p_cfg_reserved)
      else $error("reserved configuration bits set");

   property p_quiet_integration_toggle;
      $rose(shift_clock) |-> !integration_toggle_q;
   endproperty
   a_quiet_integration_toggle: assert property (p_quiet_integration_toggle)
      else $error("shifting during conversion");

   c_ready: cover property ($fell(result_ready_n));
   c_shift: cover property ($rose(shift_clock));
   c_div: cover property ($fell(result_ready_n) && cfg_word[CFG_CLKDIV]);
endmodule : cac_link_checker

// File: tb/current_adc_readout_control_tb.sv
`timescale 1ns/10ps
module current_adc_readout_control_tb
   import cac_pkg::*;
;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic over_range;
   logic clock_fault;
   logic integration_toggle_busy;
   logic chain_in = 1'b1;
   logic [CHANNELS*WORD20-1:0] chan_charge;
   logic sc_p = 1'b0;
   logic busy_seen = 1'b0;
   logic bits [0:2047];
   int nbits = 0;
   int mismatches = 0;
   int cmp_count = 0;
   logic [31:0] d;
   logic e;

   cac_link_if link();
   cac_host cac_host_i(.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .link(link));
   // Short conversion and a 5 MHz master rate keep the run brief and fault free
   cac_device #(.INTEGRATION_TOGGLE_CYC(8), .MDIV(8)) cac_device_i(.sys_clk(sys_clk), .nrst(nrst),
      .link(link), .chan_charge(chan_charge), .chain_in(chain_in),
      .over_range(over_range), .clock_fault(clock_fault), .integration_toggle_busy(integration_toggle_busy));
   cac_link_checker cac_link_checker_i(.sys_clk(sys_clk), .nrst(nrst),
      .integration_toggle(link.integration_toggle), .result_ready_n(link.result_ready_n),
      .shift_clock(link.shift_clock), .data_out(link.data_out), .cfg_word(link.cfg_word));

   // ---------------------------------------------------------------
   // Clock, link capture, watchdog
   // ---------------------------------------------------------------
   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      sc_p <= link.shift_clock;
      if (integration_toggle_busy) busy_seen <= 1'b1;
      if (link.shift_clock && !sc_p) begin
         if (nbits < 2048) begin
            bits[nbits] = link.data_out;
         end
         nbits++;
      end
   end

   initial begin
      #3_000_000;
      mismatches++;
      conclude();
   end

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   function automatic logic [19:0] exp_w(input int c);
      return (c == 1) ? 20'h0_2af8 : 20'(c) * 20'h0_00e1;
   endfunction : exp_w

   task automatic conclude();
      $display("Mismatches %0d, comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      if (pready !== 1'b1) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, pready, 1'b1);
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [31:0] r;
      logic er;
      apb(1'b1, a, v, r, er);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      logic er;
      apb(1'b0, a, 32'h0000_0000, v, er);
   endtask : rd

   task automatic settle();
      repeat (3) @(posedge sys_clk);
   endtask : settle

   // Runs the toggle until one frame has been shifted, then stops it
   task automatic frame(input logic [31:0] half, input logic [31:0] ctrl);
      int i;
      wr(ADDR_HALF, half);
      nbits = 0;
      wr(ADDR_CTRL, ctrl | 32'h0000_0001);
      for (i = 0; i < 2 * half + 2000 && irq !== 1'b1; i++) @(posedge sys_clk);
      chk(32'(irq), 32'h0000_0001);
      wr(ADDR_CTRL, ctrl);
   endtask : frame

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin : main
      int c;
      int b;
      int ones;
      logic [19:0] w;
      for (c = 0; c < CHANNELS; c++) chan_charge[c*WORD20 +: WORD20] = exp_w(c);
      repeat (16) @(posedge sys_clk);
      nrst <= 1'b1;
      rd(ADDR_CTRL, d);
      chk(d, 32'h0000_01c0);
      rd(ADDR_HALF, d);
      chk(d, HALF_RST);
      rd(ADDR_INT_EN, d);
      chk(d, 32'h0000_0000);
      rd(ADDR_INT_STAT, d);
      chk(d, 32'h0000_0000);
      apb(1'b0, 8'h20, 32'h0000_0000, d, e);
      chk(d, 32'h0000_0000);
      chk(32'(e), 32'h0000_0001);
      apb(1'b1, 8'h02, 32'hffff_ffff, d, e);
      chk(32'(e), 32'h0000_0001);
      wr(ADDR_INT_EN, 32'h0000_0002);
      // 20-bit words, range three, one device, timed start
      wr(ADDR_DELAY, 32'h0000_0080);
      rd(ADDR_DELAY, d);
      chk(d, 32'h0000_0080);
      frame(32'h0000_52d0, 32'h0000_01ca);
      chk(32'(link.cfg_word), 32'h0000_0700);
      chk(32'(nbits), 32'(CHANNELS * WORD20));
      for (c = 0; c < CHANNELS; c++) begin
         w = 20'h0_0000;
         for (b = 0; b < WORD20; b++) w = {w[18:0], bits[c*WORD20+b]};
         chk(32'(w), 32'(exp_w(c)));
      end
      rd(ADDR_STATUS, d);
      chk(d, 32'h0000_000c);
      chk(32'(busy_seen), 32'h0000_0001);
      chk(32'(integration_toggle_busy), 32'h0000_0000);
      rd(ADDR_DATA, d);
      chk(d, 32'(exp_w(63)));
      chk(32'(over_range), 32'h0000_0000);
      rd(ADDR_INT_STAT, d);
      chk(d & 32'h0000_0002, 32'h0000_0002);
      wr(ADDR_INT_EN, 32'h0000_0000);
      settle();
      chk(32'(irq), 32'h0000_0000);
      wr(ADDR_INT_EN, 32'h0000_0002);
      settle();
      chk(32'(irq), 32'h0000_0001);
      wr(ADDR_INT_CLR, 32'h0000_0002);
      settle();
      chk(32'(irq), 32'h0000_0000);
      rd(ADDR_INT_STAT, d);
      chk(d & 32'h0000_0002, 32'h0000_0000);
      // 16-bit words, range two, divider on, two chained devices
      frame(32'h0000_83a4, 32'h0000_0290);
      chk(32'(link.cfg_word), 32'h0000_2400);
      chk(32'(nbits), 32'h0000_0800);
      ones = 0;
      for (b = 1024; b < 2048; b++) ones += int'(bits[b] === 1'b1);
      chk(32'(ones), 32'h0000_0400);
      chk(32'(over_range), 32'h0000_0001);
      chk(32'(clock_fault), 32'h0000_0000);
      rd(ADDR_DATA, d);
      chk(d, 32'h0000_ffff);
      conclude();
   end
endmodule : current_adc_readout_control_tb
